// ### dv/pcf_ref_src.sv
/*
 * Reference clock source and board load model for the fan-out block.
 * Assumes the bench picks the reference half period and the wired-back bank.
 */
module pcf_ref_src (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Reference control.
	input wire logic i_run,
	input wire logic i_level,
	input wire logic [1:0] i_half,
	input wire logic [1:0] i_fb_bank,
	// Loads.
	input wire logic [11:0] i_pins,
	input wire logic [11:0] i_oe,
	output logic [1:0] o_ref,
	output logic o_fb
);
	timeunit 1ns;
	timeprecision 1ns;
	logic lvl_reg;
	logic flt_reg;
	logic [1:0] cnt_reg;
	int fb_idx;
	// ==========================================================
	// Reference: fixed period while running, a static level otherwise.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lvl_reg <= 1'b0;
			cnt_reg <= 2'h0;
			flt_reg <= 1'b0;
		end else begin
			flt_reg <= ~flt_reg;
			if (!i_run) begin
				lvl_reg <= i_level;
				cnt_reg <= 2'h0;
			end else if (cnt_reg + 2'h1 == i_half) begin
				lvl_reg <= ~lvl_reg;
				cnt_reg <= 2'h0;
			end else begin
				cnt_reg <= cnt_reg + 2'h1;
			end
		end
	end
	assign o_ref = {lvl_reg, ~lvl_reg};
	// A floating wire toggles, so a released pin never looks like a held level.
	assign fb_idx = 3 * int'(i_fb_bank);
	assign o_fb = i_oe[fb_idx] ? i_pins[fb_idx] : flt_reg;
endmodule

// ### dv/test_pcf_top.sv
/*
 * Self-checking bench for the clock fan-out top.
 * Assumes the partner model drives reference and feedback.
 */
module test_pcf_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_n, psel, pen, pwr, pready, pslverr, run, lvl, fb, er;
	logic [11:0] paddr, oe, pins;
	logic [31:0] pwdata, prdata, v, c;
	logic [2:0] b1, b2, b3, b4;
	logic [1:0] half, fbb, refp, s;
	logic [3:0] pat [2];
	int bad_count, checks, seed;
	assign pins = {b4, b3, b2, b1};
	pcf_top #(.P_STAB_CYCLES(20)) uut (.I_CLOCK(clk), .I_RST_N(rst_n), .I_REF_CLOCK_IN_PAIR(refp),
		.I_LOOP_FEEDBACK_IN(fb), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
		.I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
		.O_BANK1_CLOCK_OUT(b1), .O_BANK2_CLOCK_OUT(b2), .O_BANK3_CLOCK_OUT(b3),
		.O_BANK4_CLOCK_OUT(b4), .O_CLOCK_OUT_OE(oe));
	pcf_ref_src src (.i_clk(clk), .i_rst_n(rst_n), .i_run(run), .i_level(lvl), .i_half(half),
		.i_fb_bank(fbb), .i_pins(pins), .i_oe(oe), .o_ref(refp), .o_fb(fb));
	// ==========================================================
	// Checking and closing.
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task conclude();
		if (bad_count == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task fail_out(input string what);
		check(what, 32'h0, 32'h1);
		conclude();
	endtask
	// ==========================================================
	// APB master: held until pready is sampled high at a rising edge, then released.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) fail_out("apb ready");
		v = prdata;
		er = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	function automatic logic [31:0] ctl(logic [1:0] sl, logic oe_n, logic t, logic cn);
		ctl = 32'h0;
		ctl[pcf_pkg::CTRL_SEL_LO_BIT] = sl[0];
		ctl[pcf_pkg::CTRL_SEL_HI_BIT] = sl[1];
		ctl[pcf_pkg::CTRL_OE_N_BIT] = oe_n;
		ctl[pcf_pkg::CTRL_TEST_BIT] = t;
		ctl[pcf_pkg::CTRL_CLR_N_BIT] = cn;
	endfunction
	// Banks whose index is below the select code run at the quarter rate.
	function automatic int exp_tog(int b, logic [1:0] sl);
		return (b < int'(sl)) ? 8 : 16;
	endfunction
	task automatic wait_lock();
		int i;
		for (i = 0; i < 100; i++) begin
			apb(1'b0, pcf_pkg::STATUS_OFFSET, 32'h0);
			if (v[pcf_pkg::STAT_LOCK_BIT] === 1'b1) return;
		end
		fail_out("lock wait");
	endtask
	// Sixteen cycles of every bank, reference and feedback.
	task automatic measure(input logic [1:0] sl);
		logic [11:0] p0;
		logic r0, f0;
		int tog[4], hi[4], rt, ph, un;
		rt = 0;
		ph = 0;
		un = 0;
		foreach (tog[b]) begin
			tog[b] = 0;
			hi[b] = 0;
		end
		@(negedge clk);
		p0 = pins;
		r0 = refp[1];
		f0 = fb;
		repeat (16) begin
			@(negedge clk);
			for (int b = 0; b < 4; b++) begin
				hi[b] += int'(p0[b * 3]);
				tog[b] += int'(pins[b * 3] != p0[b * 3]);
				un += int'(!(pins[b * 3 +: 3] == 3'h0 || pins[b * 3 +: 3] == 3'h7));
			end
			rt += int'(refp[1] != r0);
			ph += int'((refp[1] & !r0) != (fb & !f0));
			p0 = pins;
			r0 = refp[1];
			f0 = fb;
		end
		for (int b = 0; b < 4; b++) begin
			check("bank toggles", 32'(tog[b]), 32'(exp_tog(b, sl)));
			check("bank duty", 32'(hi[b]), 32'h8);
		end
		check("pin match", 32'(un), 32'h0);
		check("fb to ref", 32'(rt), 32'(tog[fbb]));
		check("phase", 32'(ph), 32'h0);
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ==========================================================
	// Main sequence.
	initial begin
		seed = 11;
		bad_count = 0;
		checks = 0;
		{psel, pen, pwr, lvl, rst_n} = 5'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		run = 1'b1;
		half = 2'h1;
		fbb = 2'h3;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, pcf_pkg::CTRL_OFFSET, 32'h0);
		check("ctrl reset", v, 32'h14);
		check("oe reset", 32'(oe), 32'h0);
		apb(1'b1, 12'h100 | (12'($random(seed)) & 12'h0fc), 32'h0);
		check("unmapped err", 32'(er), 32'h1);
		apb(1'b1, pcf_pkg::CTRL_OFFSET, ctl(2'h0, 1'b0, 1'b0, 1'b1));
		@(negedge clk);
		check("oe latency", 32'(oe), 32'h0);
		@(negedge clk);
		check("oe on", 32'(oe), 32'hfff);
		for (int k = 0; k < 6; k++) begin
			// Random codes step by one or two so that every write is a real change.
			s = (k < 4) ? 2'(k) : s + 2'h1 + 2'($random(seed) & 32'h1);
			c = ctl(s, 1'b0, 1'b0, 1'b1);
			apb(1'b1, pcf_pkg::CTRL_OFFSET, c | (32'($random(seed)) & 32'hffffffe0));
			apb(1'b0, pcf_pkg::STATUS_OFFSET, 32'h0);
			check("relock", 32'(v[pcf_pkg::STAT_LOCK_BIT]), 32'h0);
			apb(1'b0, pcf_pkg::CTRL_OFFSET, 32'h0);
			check("ctrl read", v, c);
			wait_lock();
			measure(s);
		end
		// Quarter pin wired back with a slower reference.
		fbb = 2'h0;
		half = 2'h2;
		apb(1'b1, pcf_pkg::CTRL_OFFSET, ctl(2'h1, 1'b1, 1'b0, 1'b1));
		apb(1'b1, pcf_pkg::CTRL_OFFSET, ctl(2'h1, 1'b0, 1'b0, 1'b1));
		wait_lock();
		measure(2'h1);
		fbb = 2'h3;
		half = 2'h1;
		for (int j = 0; j < 2; j++) begin
			apb(1'b1, pcf_pkg::CTRL_OFFSET, ctl(2'h3, 1'b0, 1'b0, 1'b1));
			// Settled loop, and an even number of cycles between the two clears.
			wait_lock();
			apb(1'b1, pcf_pkg::CTRL_OFFSET, ctl(2'h3, 1'b0, 1'b0, 1'b0));
			repeat (2) @(posedge clk);
			for (int n = 0; n < 4; n++) begin
				@(negedge clk);
				pat[j][n] = b1[0];
			end
			check("clear low", 32'(pat[j][0]), 32'h0);
		end
		check("clear phase", 32'(pat[1]), 32'(pat[0]));
		apb(1'b1, pcf_pkg::CTRL_OFFSET, ctl(2'h3, 1'b1, 1'b0, 1'b1));
		repeat (2) @(negedge clk);
		check("oe off", 32'(oe), 32'h0);
		repeat (40) @(posedge clk);
		apb(1'b0, pcf_pkg::STATUS_OFFSET, 32'h0);
		check("no lock off", 32'(v[pcf_pkg::STAT_LOCK_BIT]), 32'h0);
		apb(1'b1, pcf_pkg::CTRL_OFFSET, ctl(2'h3, 1'b0, 1'b0, 1'b1));
		apb(1'b0, pcf_pkg::STATUS_OFFSET, 32'h0);
		check("settle on", 32'(v[pcf_pkg::STAT_LOCK_BIT]), 32'h0);
		wait_lock();
		// Bypass with the reference parked at each level.
		run <= 1'b0;
		lvl <= 1'b1;
		apb(1'b1, pcf_pkg::CTRL_OFFSET, ctl(2'h3, 1'b0, 1'b1, 1'b1));
		repeat (4) @(negedge clk);
		check("bypass high", 32'(pins), 32'hfff);
		apb(1'b0, pcf_pkg::STATUS_OFFSET, 32'h0);
		check("bypass flag", 32'(v[pcf_pkg::STAT_BYPASS_BIT]), 32'h1);
		lvl <= 1'b0;
		repeat (4) @(negedge clk);
		check("bypass low", 32'(pins), 32'h0);
		run <= 1'b1;
		apb(1'b1, pcf_pkg::CTRL_OFFSET, ctl(2'h3, 1'b0, 1'b0, 1'b1));
		apb(1'b0, pcf_pkg::STATUS_OFFSET, 32'h0);
		check("bypass exit", 32'(v[pcf_pkg::STAT_LOCK_BIT]), 32'h0);
		wait_lock();
		measure(2'h3);
		conclude();
	end
endmodule

// ### hw/pcf_div_if.sv
/*
 * Carrier between the fan-out top and its oscillator divider.
 * Assumes both ends sit in the same clock domain.
 */
interface pcf_div_if;

	// Steering towards the divider.
	logic hold;
	logic clear;
	// Divided rates back to the top.
	logic half;
	logic quarter;

	modport ctrl (output hold, output clear, input half, input quarter);
	modport div (input hold, input clear, output half, output quarter);

endinterface

// ### hw/pcf_divider.sv
/*
 * Oscillator divider: makes the half and quarter rates as toggle flops.
 * Assumes the clock is the oscillator and hold/clear come from the top.
 */
module pcf_divider (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Divider control and rates.
	pcf_div_if.div dv
);

	logic half_reg;
	logic half_next;
	logic quarter_reg;
	logic quarter_next;

	// ==========================================================
	// Toggle dividers.
	// A hold freezes both rates for one cycle, which slips their phase
	// against the reference; clear forces the quarter rate low.
	always_comb begin
		half_next = half_reg;
		quarter_next = quarter_reg;
		if (!dv.hold) begin
			half_next = ~half_reg; // RQ18 RQ21 RQ3
			quarter_next = quarter_reg ^ half_reg; // RQ18 RQ21 RQ3
		end
		if (dv.clear) begin
			quarter_next = 1'b0; // RQ7
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			half_reg <= 1'b0;
			quarter_reg <= 1'b0;
		end else begin
			half_reg <= half_next;
			quarter_reg <= quarter_next;
		end
	end

	assign dv.half = half_reg;
	assign dv.quarter = quarter_reg;

	// ==========================================================
	// Checks.
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	a_half_toggles: assert property (!dv.hold |=> half_reg != $past(half_reg)) // RQ3
		else $error("half rate did not toggle");
	a_quarter_cleared: assert property (dv.clear |=> !quarter_reg) // RQ7
		else $error("quarter rate not cleared");
	a_quarter_duty: assert property (!dv.hold && !dv.clear && !half_reg |=> $stable(quarter_reg)) // RQ18
		else $error("quarter rate toggled early");

endmodule

// ### hw/pcf_pkg.sv
/*
 * Shared constants for the clock fan-out block: register map, field
 * positions, reset values, bank layout, settle timing and lock states.
 * Assumes a 100 MHz system clock that stands in for the loop oscillator.
 */
package pcf_pkg;

	// ==========================================================
	// Register map (byte addresses on the APB bus).
	localparam logic [11:0] CTRL_OFFSET = 12'h000;
	localparam logic [11:0] STATUS_OFFSET = 12'h004;

	// ==========================================================
	// Control register fields.
	localparam int CTRL_SEL_LO_BIT = 0;
	localparam int CTRL_SEL_HI_BIT = 1;
	localparam int CTRL_OE_N_BIT = 2;
	localparam int CTRL_TEST_BIT = 3;
	localparam int CTRL_CLR_N_BIT = 4;
	localparam int CTRL_WIDTH = 5;
	// Outputs disabled and clear held high until software says otherwise.
	localparam logic [4:0] CTRL_RESET = 5'h14;

	// ==========================================================
	// Status register fields.
	localparam int STAT_LOCK_BIT = 0;
	localparam int STAT_BYPASS_BIT = 1;
	localparam int STAT_HALF_BIT = 2;
	localparam int STAT_QUARTER_BIT = 3;

	// ==========================================================
	// Bank layout.
	localparam int NUM_BANKS = 4;
	localparam int OUTS_PER_BANK = 3;
	localparam int ALT_BANKS = 3;

	// ==========================================================
	// Settle interval after power-up, select change or output enable.
	localparam int CLOCK_MHZ = 100;
	localparam int STAB_TIME_US = 50;
	localparam int STAB_CYCLES = STAB_TIME_US * CLOCK_MHZ;

	// ==========================================================
	// Loop lock states.
	typedef enum logic [1:0] {
		PCF_ST_SETTLE,
		PCF_ST_LOCKED,
		PCF_ST_BYPASS
	} pcf_lock_e;

endpackage

// ### hw/pcf_top.sv
/*
 * Clock fan-out top: twelve outputs in four banks of three, fed from the
 * oscillator divider, with phase slip towards the reference, lock timing,
 * loop bypass and an APB control/status slave.
 * Assumes all inputs are synchronous to I_CLOCK, which models the
 * oscillator, and that one output is wired back to the feedback input.
 */
// Behaviour
// RQ1: Banks one to three run half or quarter
// RQ2: Bank four always runs half rate
// RQ3: All outputs have fifty percent duty
// RQ4: Enable low drives all twelve outputs
// RQ5: Enable high floats all twelve outputs
// RQ6: Enable falling edge restarts settle interval
// RQ7: Clear falling edge resets quarter divider
// RQ8: Outside party keeps clear static normally
// RQ9: Bypass low routes outputs through loop
// RQ10: Bypass high routes reference straight out
// RQ11: Outside party ties bypass low normally
// RQ12: Outside party wires one output back
// RQ13: Loop slips until feedback meets reference
// RQ14: Reference must be fixed frequency, phase
// RQ15: Settle interval needed after power-up
// RQ16: Output ratio follows select and feedback
// RQ17: Select sets each bank's rate separately
// RQ18: Oscillator divided by two and four
// RQ19: Select code puts banks 1,1-2,1-3 alternate
// RQ20: Select change restarts settle interval
// RQ21: Oscillator modelled by clock, toggle dividers
module pcf_top #(
	parameter int P_STAB_CYCLES = pcf_pkg::STAB_CYCLES
) (
	// Clock and reset.
	input wire logic I_CLOCK,
	input wire logic I_RST_N,
	// Reference pair (bit 1 true leg, bit 0 complement) and feedback.
	input wire logic [1:0] I_REF_CLOCK_IN_PAIR,
	input wire logic I_LOOP_FEEDBACK_IN,
	// APB slave.
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [11:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	// Clock outputs and their drive enables.
	output logic [2:0] O_BANK1_CLOCK_OUT,
	output logic [2:0] O_BANK2_CLOCK_OUT,
	output logic [2:0] O_BANK3_CLOCK_OUT,
	output logic [2:0] O_BANK4_CLOCK_OUT,
	output logic [11:0] O_CLOCK_OUT_OE
);

	localparam int CW = $clog2(P_STAB_CYCLES + 1);
	localparam logic [CW-1:0] CNT_LAST = CW'(P_STAB_CYCLES - 1);
	localparam int NOUT = pcf_pkg::NUM_BANKS * pcf_pkg::OUTS_PER_BANK;

	if (P_STAB_CYCLES < 2) begin : g_bad_stab
		$error("P_STAB_CYCLES must be at least 2");
	end

	// ==========================================================
	// Control register and APB slave.
	logic [pcf_pkg::CTRL_WIDTH-1:0] ctrl_reg;
	logic [pcf_pkg::CTRL_WIDTH-1:0] ctrl_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic pready_reg;
	logic pready_next;
	logic pslverr_reg;
	logic pslverr_next;
	logic [31:0] status_word;
	logic setup_phase;
	logic mapped;
	logic [1:0] sel;
	logic oe_n;
	logic test;
	logic clr_n;
	pcf_pkg::pcf_lock_e state_reg;
	pcf_pkg::pcf_lock_e state_next;
	pcf_div_if dv ();

	assign sel = {ctrl_reg[pcf_pkg::CTRL_SEL_HI_BIT], ctrl_reg[pcf_pkg::CTRL_SEL_LO_BIT]};
	assign oe_n = ctrl_reg[pcf_pkg::CTRL_OE_N_BIT];
	assign test = ctrl_reg[pcf_pkg::CTRL_TEST_BIT];
	assign clr_n = ctrl_reg[pcf_pkg::CTRL_CLR_N_BIT];
	assign setup_phase = I_PSEL && !I_PENABLE;
	assign mapped = (I_PADDR == pcf_pkg::CTRL_OFFSET) || (I_PADDR == pcf_pkg::STATUS_OFFSET);

	// Status word gathers the live lock and divider state.
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[pcf_pkg::STAT_LOCK_BIT] = (state_reg == pcf_pkg::PCF_ST_LOCKED);
		status_word[pcf_pkg::STAT_BYPASS_BIT] = (state_reg == pcf_pkg::PCF_ST_BYPASS);
		status_word[pcf_pkg::STAT_HALF_BIT] = dv.half;
		status_word[pcf_pkg::STAT_QUARTER_BIT] = dv.quarter;
	end

	// Every transfer gets exactly one access cycle; read data is latched
	// in the setup cycle so the bus output comes straight from a flop.
	always_comb begin
		ctrl_next = ctrl_reg;
		prdata_next = prdata_reg;
		pready_next = setup_phase;
		pslverr_next = setup_phase && !mapped;
		if (setup_phase) begin
			prdata_next = 32'h0000_0000;
			if (!I_PWRITE && I_PADDR == pcf_pkg::CTRL_OFFSET) begin
				prdata_next = {27'h0000000, ctrl_reg};
			end else if (!I_PWRITE && I_PADDR == pcf_pkg::STATUS_OFFSET) begin
				prdata_next = status_word;
			end
		end
		if (I_PSEL && I_PENABLE && pready_reg && I_PWRITE && I_PADDR == pcf_pkg::CTRL_OFFSET) begin
			ctrl_next = I_PWDATA[pcf_pkg::CTRL_WIDTH-1:0];
		end
	end

	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			ctrl_reg <= pcf_pkg::CTRL_RESET;
			prdata_reg <= 32'h0000_0000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	assign O_PRDATA = prdata_reg;
	assign O_PREADY = pready_reg;
	assign O_PSLVERR = pslverr_reg;

	// ==========================================================
	// Input edge tracking.
	// The reference level only moves while the two legs disagree, so a
	// collapsed pair freezes it rather than inventing edges.
	logic ref_lvl_reg;
	logic ref_lvl_next;
	logic [1:0] slip_hist_reg;
	logic fb_prev_reg;
	logic [1:0] sel_prev_reg;
	logic oe_n_prev_reg;
	logic clr_n_prev_reg;
	logic ref_rise;
	logic fb_rise;
	logic slip;
	logic restart;

	always_comb begin
		ref_lvl_next = ref_lvl_reg;
		if (I_REF_CLOCK_IN_PAIR[1] != I_REF_CLOCK_IN_PAIR[0]) begin
			ref_lvl_next = I_REF_CLOCK_IN_PAIR[1];
		end
	end

	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			ref_lvl_reg <= 1'b0;
			slip_hist_reg <= 2'h0;
			fb_prev_reg <= 1'b0;
			sel_prev_reg <= 2'h0;
			oe_n_prev_reg <= 1'b1;
			clr_n_prev_reg <= 1'b1;
		end else begin
			ref_lvl_reg <= ref_lvl_next;
			slip_hist_reg <= {slip_hist_reg[0], slip};
			fb_prev_reg <= I_LOOP_FEEDBACK_IN;
			sel_prev_reg <= sel;
			oe_n_prev_reg <= oe_n;
			clr_n_prev_reg <= clr_n;
		end
	end

	// Both edges come from the pin levels of the same sample, so lock means
	// that the two pins rise together and not one oscillator cycle apart.
	assign ref_rise = ref_lvl_next && !ref_lvl_reg;
	assign fb_rise = I_LOOP_FEEDBACK_IN && !fb_prev_reg;
	// A reference edge without a feedback edge slips the dividers by one
	// oscillator cycle; with the feedback pin floating there is nothing to
	// compare, so no slip is made then. A slip reaches the feedback pin two
	// edges later, so the two samples after it see a stretched level and
	// must not slip again, or a half-rate loop would never settle.
	assign slip = (state_reg != pcf_pkg::PCF_ST_BYPASS) && !oe_n && ref_rise && !fb_rise // RQ13
		&& (slip_hist_reg == 2'h0);
	// Anything that disturbs reference or feedback starts the settle over.
	assign restart = slip || oe_n || (sel != sel_prev_reg) || (!oe_n && oe_n_prev_reg); // RQ6 RQ20

	assign dv.hold = slip; // RQ13 RQ16
	assign dv.clear = clr_n_prev_reg && !clr_n; // RQ7

	pcf_divider u_divider (
		.i_clk(I_CLOCK),
		.i_rst_n(I_RST_N),
		.dv(dv)
	);

	// ==========================================================
	// Lock state and settle counter.
	logic [CW-1:0] stab_cnt_reg;
	logic [CW-1:0] stab_cnt_next;

	always_comb begin
		state_next = state_reg;
		stab_cnt_next = stab_cnt_reg;
		case (state_reg)
			pcf_pkg::PCF_ST_SETTLE: begin
				if (test) begin
					state_next = pcf_pkg::PCF_ST_BYPASS; // RQ10
				end else if (restart) begin
					stab_cnt_next = '0; // RQ6 RQ20
				end else if (stab_cnt_reg == CNT_LAST) begin
					state_next = pcf_pkg::PCF_ST_LOCKED; // RQ15
				end else begin
					stab_cnt_next = stab_cnt_reg + CW'(1); // RQ15
				end
			end
			pcf_pkg::PCF_ST_LOCKED: begin
				if (test) begin
					state_next = pcf_pkg::PCF_ST_BYPASS;
				end else if (restart) begin
					state_next = pcf_pkg::PCF_ST_SETTLE;
					stab_cnt_next = '0;
				end
			end
			pcf_pkg::PCF_ST_BYPASS: begin
				if (!test) begin
					// Re-entering the loop needs a fresh settle interval.
					state_next = pcf_pkg::PCF_ST_SETTLE; // RQ9
					stab_cnt_next = '0;
				end
			end
			default: begin
				state_next = pcf_pkg::PCF_ST_SETTLE;
				stab_cnt_next = '0;
			end
		endcase
	end

	// Reset is the power-up case: the settle interval starts from zero.
	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state_reg <= pcf_pkg::PCF_ST_SETTLE;
			stab_cnt_reg <= '0;
		end else begin
			state_reg <= state_next;
			stab_cnt_reg <= stab_cnt_next;
		end
	end

	// ==========================================================
	// Output banks.
	// Banks below the select code take the quarter rate, the rest the
	// half rate; bypass copies the reference straight to every pin.
	logic [NOUT-1:0] out_reg;
	logic [NOUT-1:0] out_next;
	logic [NOUT-1:0] oe_reg;
	logic [NOUT-1:0] oe_next;

	for (genvar b = 0; b < pcf_pkg::NUM_BANKS; b++) begin : g_bank
		logic bank_clk;
		if (b < pcf_pkg::ALT_BANKS) begin : g_alt
			assign bank_clk = (32'(sel) > b) ? dv.quarter : dv.half; // RQ1 RQ17 RQ19
		end else begin : g_fixed
			assign bank_clk = dv.half; // RQ2
		end
		assign out_next[b*pcf_pkg::OUTS_PER_BANK +: pcf_pkg::OUTS_PER_BANK] =
			{pcf_pkg::OUTS_PER_BANK{(state_reg == pcf_pkg::PCF_ST_BYPASS) ? ref_lvl_reg : bank_clk}}; // RQ9 RQ10
	end

	assign oe_next = {NOUT{!oe_n}}; // RQ4 RQ5

	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			out_reg <= '0;
			oe_reg <= '0;
		end else begin
			out_reg <= out_next;
			oe_reg <= oe_next;
		end
	end

	assign O_BANK1_CLOCK_OUT = out_reg[2:0];
	assign O_BANK2_CLOCK_OUT = out_reg[5:3];
	assign O_BANK3_CLOCK_OUT = out_reg[8:6];
	assign O_BANK4_CLOCK_OUT = out_reg[11:9];
	assign O_CLOCK_OUT_OE = oe_reg;

	// ==========================================================
	// Checks.
	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (!I_RST_N);

	sequence seq_loop_path;
		state_reg != pcf_pkg::PCF_ST_BYPASS;
	endsequence
	sequence seq_oe_fall;
		!oe_n && oe_n_prev_reg;
	endsequence
	sequence seq_settle_start;
		state_reg == pcf_pkg::PCF_ST_SETTLE && stab_cnt_reg == '0;
	endsequence

	a_bank1_quarter: assert property (seq_loop_path and (sel != 2'h0) |=> O_BANK1_CLOCK_OUT == {3{$past(dv.quarter)}}) // RQ1
		else $error("bank one not on quarter rate");
	a_bank3_half: assert property (seq_loop_path and (sel != 2'h3) |=> O_BANK3_CLOCK_OUT == {3{$past(dv.half)}}) // RQ19
		else $error("bank three not on half rate");
	a_bank4_half: assert property (seq_loop_path |=> O_BANK4_CLOCK_OUT == {3{$past(dv.half)}}) // RQ2
		else $error("bank four not on half rate");
	a_oe_drive: assert property (!oe_n |=> O_CLOCK_OUT_OE == 12'hfff) // RQ4
		else $error("outputs not driven");
	a_oe_float: assert property (oe_n |=> O_CLOCK_OUT_OE == 12'h000) // RQ5
		else $error("outputs not floated");
	a_oe_relock: assert property (seq_oe_fall and seq_loop_path and !test |=> seq_settle_start) // RQ6
		else $error("enable edge did not restart settle");
	a_sel_relock: assert property ((sel != sel_prev_reg) and !test |=> seq_settle_start) // RQ20
		else $error("select change did not restart settle");
	a_bypass_path: assert property ((state_reg == pcf_pkg::PCF_ST_BYPASS) |=> out_reg == {12{$past(ref_lvl_reg)}}) // RQ10
		else $error("bypass not following reference");
	a_bypass_exit: assert property ((state_reg == pcf_pkg::PCF_ST_BYPASS) && !test |=> seq_settle_start) // RQ9
		else $error("loop path not resumed");
	a_slip_unlock: assert property (slip |=> state_reg != pcf_pkg::PCF_ST_LOCKED) // RQ13
		else $error("locked while phase still slipping");
	a_settle_time: assert property ($rose(state_reg == pcf_pkg::PCF_ST_LOCKED) |-> $past(stab_cnt_reg) == CNT_LAST) // RQ15
		else $error("lock reported before settle interval");

endmodule
